// File: rtl/hsdi_top.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Host port, command/status and serial word converter
module hsdi_top (
    input  wire logic                        clk_sys,
    input  wire logic                        reset_n,
    input  wire logic                        ioAccessStrobeN,
    input  wire logic                        hostWriteNotRead,
    input  wire logic [3:0]                  hostAddr,
    input  wire logic [hsdi_pkg::HOST_W-1:0] hostDataIn,
    output logic      [hsdi_pkg::HOST_W-1:0] hostDataOut,
    output logic                             hostDataOe,
    output logic                             busBufferEnableN,
    input  wire logic [2:0]                  baseAddrSwitch,
    input  wire logic                        clockSourceSelect,
    input  wire logic                        extClk2400,
    input  wire logic                        extClk432,
    input  wire logic                        serialDataIn,
    output logic                             serialDataOut,
    input  wire logic                        frameRefPulse,
    output logic                             frameRefPulseOut,
    output logic                             txHoldReady,
    output logic      [hsdi_pkg::HOST_W-1:0] debugLatch1,
    output logic      [hsdi_pkg::HOST_W-1:0] debugLatch2,
    output logic      [hsdi_pkg::HOST_W-1:0] debugLatch3
);
    import hsdi_pkg::*;

    // ==========================================
    // Pin synchronisers
    localparam int PIN_W = 30;
    logic [PIN_W-1:0] pinMeta_r;
    logic [PIN_W-1:0] pinSync_r;

    // Two flops on every pin before use
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            pinMeta_r <= '1;
            pinSync_r <= '1;
        end else begin
            pinMeta_r <= {ioAccessStrobeN, hostWriteNotRead, hostAddr,
                          hostDataIn, baseAddrSwitch, clockSourceSelect,
                          extClk2400, extClk432, serialDataIn,
                          frameRefPulse};
            pinSync_r <= pinMeta_r;
        end
    end

    logic              strobeN_s;
    logic              wnr_s;
    logic [3:0]        addr_s;
    logic [HOST_W-1:0] data_s;
    logic [2:0]        base_s;
    logic              clkSel_s;
    logic              clk2400_s;
    logic              clk432_s;
    logic              rxIn_s;
    logic              frameIn_s;
    assign {strobeN_s, wnr_s, addr_s, data_s, base_s, clkSel_s,
            clk2400_s, clk432_s, rxIn_s, frameIn_s} = pinSync_r;

    // ==========================================
    // Address decode
    logic hit;
    logic writeDataSelectN;
    logic readDataSelectN;
    logic writeCommandSelectN;
    logic readStatusSelectN;
    assign hit = !strobeN_s && (addr_s[3:1] == base_s);
    assign writeDataSelectN    = !(hit && !wnr_s && !addr_s[0]);
    assign readDataSelectN     = !(hit &&  wnr_s && !addr_s[0]);
    assign writeCommandSelectN = !(hit && !wnr_s &&  addr_s[0]);
    assign readStatusSelectN   = !(hit &&  wnr_s &&  addr_s[0]);

    // Previous selects and data held during access
    logic              wrDataSelN_q;
    logic              rdDataSelN_q;
    logic              wrCmdSelN_q;
    logic              rdStatSelN_q;
    logic [HOST_W-1:0] dataLast_r;
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            wrDataSelN_q <= 1'b1;
            rdDataSelN_q <= 1'b1;
            wrCmdSelN_q  <= 1'b1;
            rdStatSelN_q <= 1'b1;
            dataLast_r   <= HOST_ZERO;
        end else begin
            wrDataSelN_q <= writeDataSelectN;
            rdDataSelN_q <= readDataSelectN;
            wrCmdSelN_q  <= writeCommandSelectN;
            rdStatSelN_q <= readStatusSelectN;
            if (hit) begin
                dataLast_r <= data_s;
            end
        end
    end

    // Access ends on the rising edge of a select
    logic wrDataEnd;
    logic rdDataEnd;
    logic wrCmdEnd;
    logic rdStatEnd;
    assign wrDataEnd = writeDataSelectN && !wrDataSelN_q;
    assign rdDataEnd = readDataSelectN && !rdDataSelN_q;
    assign wrCmdEnd  = writeCommandSelectN && !wrCmdSelN_q;
    assign rdStatEnd = readStatusSelectN && !rdStatSelN_q;

    // Data buffer enable, low only while addressed
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            busBufferEnableN <= 1'b1;
        end else begin
            busBufferEnableN <= !hit;
        end
    end

    // ==========================================
    // Command register
    logic [1:0] destSel_r;
    logic       swReset_r;
    logic       boardRst;
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            destSel_r        <= DEST_TX_HOLD;
            frameRefPulseOut <= 1'b0;
            swReset_r        <= 1'b0;
        end else if (wrCmdEnd) begin
            destSel_r        <= dataLast_r[CMD_DEST_LSB +: 2];
            frameRefPulseOut <= dataLast_r[CMD_FRAME_BIT];
            swReset_r        <= dataLast_r[CMD_SWRST_BIT];
        end
    end
    // Host reset is the async reset; software bit clears synchronously
    assign boardRst = swReset_r;

    // ==========================================
    // Write data destination decode
    logic txHoldSel;
    logic [2:0] debugSel;
    assign txHoldSel   = wrDataEnd && (destSel_r == DEST_TX_HOLD);
    assign debugSel[0] = wrDataEnd && (destSel_r == DEST_DEBUG1);
    assign debugSel[1] = wrDataEnd && (destSel_r == DEST_DEBUG2);
    assign debugSel[2] = wrDataEnd && (destSel_r == DEST_DEBUG3);

    // Debug latches, cleared by host reset only
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            debugLatch1 <= HOST_ZERO;
            debugLatch2 <= HOST_ZERO;
            debugLatch3 <= HOST_ZERO;
        end else begin
            if (debugSel[0]) debugLatch1 <= dataLast_r;
            if (debugSel[1]) debugLatch2 <= dataLast_r;
            if (debugSel[2]) debugLatch3 <= dataLast_r;
        end
    end

    // ==========================================
    // Bit and word clock enables
    logic       clk2400_q;
    logic       clk432_q;
    logic [7:0] div432_r;
    logic [3:0] bitCnt_r;
    logic       tick432;
    logic       bitTick;
    logic       wordTick;
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            clk2400_q <= 1'b1; // Match sync preload: no edge after reset
            clk432_q  <= 1'b1;
        end else begin
            clk2400_q <= clk2400_s;
            clk432_q  <= clk432_s;
        end
    end
    assign tick432 = clk432_s && !clk432_q && (div432_r == DIV_432_LAST);
    assign bitTick = clkSel_s ? (clk2400_s && !clk2400_q) : tick432;
    assign wordTick = bitTick && (bitCnt_r == WORD_LAST);

    // Divide 432 kHz edges by 180 and bit ticks by 12
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            div432_r <= 8'h00;
            bitCnt_r <= 4'h0;
        end else if (boardRst) begin
            div432_r <= 8'h00;
            bitCnt_r <= 4'h0;
        end else begin
            if (clk432_s && !clk432_q) begin
                div432_r <= (div432_r == DIV_432_LAST) ? 8'h00
                                                       : div432_r + 8'h01;
            end
            if (bitTick) begin
                bitCnt_r <= (bitCnt_r == WORD_LAST) ? 4'h0
                                                    : bitCnt_r + 4'h1;
            end
        end
    end

    // ==========================================
    // Transmit path: hold FIFO then shifter
    hsdi_fifo_if txq ();
    assign txq.inValid  = txHoldSel;
    assign txq.inData   = dataLast_r;
    assign txq.outReady = wordTick;
    assign txHoldReady  = txq.inReady;

    hsdi_fifo #(.WIDTH(HOST_W), .DEPTH(FIFO_DEPTH)) txFifo (
        .clk_sys (clk_sys),
        .reset_n (reset_n),
        .flush   (boardRst),
        .port    (txq)
    );

    logic [WORD_W-1:0] txWord_r;
    logic [WORD_W-1:0] txShift_r;
    // Reload on word tick, else shift right so LSB leaves first
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            txWord_r  <= WORD_ZERO;
            txShift_r <= WORD_ZERO;
        end else if (boardRst) begin
            txWord_r  <= WORD_ZERO;
            txShift_r <= WORD_ZERO;
        end else if (wordTick) begin
            if (txq.outValid) begin
                txWord_r  <= txq.outData[WORD_W-1:0];
                txShift_r <= txq.outData[WORD_W-1:0];
            end else begin
                txShift_r <= txWord_r;
            end
        end else if (bitTick) begin
            txShift_r <= {1'b0, txShift_r[WORD_W-1:1]};
        end
    end
    assign serialDataOut = txShift_r[0];

    // Transmit empty and underflow flags; set wins over clear
    logic txEmpty_r;
    logic txUnder_r;
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            txEmpty_r <= 1'b0;
            txUnder_r <= 1'b0;
        end else if (boardRst) begin
            txEmpty_r <= 1'b0;
            txUnder_r <= 1'b0;
        end else if (wordTick) begin
            txEmpty_r <= 1'b1;
            txUnder_r <= txUnder_r || txEmpty_r;
        end else if (txHoldSel) begin
            txEmpty_r <= 1'b0;
            txUnder_r <= 1'b0;
        end
    end

    // ==========================================
    // Receive path
    logic [WORD_W-1:0] rxShift_r;
    logic [WORD_W-1:0] rxLatch_r;
    logic [WORD_W-1:0] rxShiftNxt;
    assign rxShiftNxt = {rxIn_s, rxShift_r[WORD_W-1:1]};
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rxShift_r <= WORD_ZERO;
            rxLatch_r <= WORD_ZERO;
        end else if (boardRst) begin
            rxShift_r <= WORD_ZERO;
            rxLatch_r <= WORD_ZERO;
        end else if (bitTick) begin
            rxShift_r <= rxShiftNxt;
            if (wordTick) begin
                rxLatch_r <= rxShiftNxt;
            end
        end
    end

    // Receive ready and overflow flags; set wins over clear
    logic rxReady_r;
    logic status_rx_overflow_r;
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rxReady_r <= 1'b0;
            status_rx_overflow_r   <= 1'b0;
        end else if (boardRst) begin
            rxReady_r <= 1'b0;
            status_rx_overflow_r   <= 1'b0;
        end else begin
            if (wordTick) begin
                rxReady_r <= 1'b1;
            end else if (rdDataEnd) begin
                rxReady_r <= 1'b0;
            end
            if (wordTick && rxReady_r) begin
                status_rx_overflow_r <= 1'b1;
            end else if (rdStatEnd) begin
                status_rx_overflow_r <= 1'b0;
            end
        end
    end

    // ==========================================
    // Read multiplexer onto host data
    logic [HOST_W-1:0] statusWord;
    always_comb begin
        statusWord = HOST_ZERO;
        statusWord[STAT_RX_READY] = rxReady_r;
        statusWord[STAT_RX_OVR]   = status_rx_overflow_r;
        statusWord[STAT_TX_EMPTY] = txEmpty_r;
        statusWord[STAT_TX_UNDER] = txUnder_r;
        statusWord[STAT_FRAME]    = frameIn_s;
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            hostDataOut <= HOST_ZERO;
            hostDataOe  <= 1'b0;
        end else begin
            hostDataOe <= !readDataSelectN || !readStatusSelectN;
            if (!readDataSelectN) begin
                hostDataOut <= {4'h0, rxLatch_r};
            end else if (!readStatusSelectN) begin
                hostDataOut <= statusWord;
            end else begin
                hostDataOut <= HOST_ZERO;
            end
        end
    end

    // ==========================================
    // Checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    sequence seqCmdWrite;
        !writeCommandSelectN ##1 writeCommandSelectN;
    endsequence
    sequence seqWordLive;
        wordTick && !boardRst;
    endsequence

    AST_BUF_EN: assert property (busBufferEnableN == !$past(hit, 1))
        else $error("buffer enable does not follow address match");
    AST_CMD_DEST: assert property (seqCmdWrite |=>
        destSel_r == $past(dataLast_r[1:0], 1))
        else $error("destination bits not captured");
    AST_FRAME_OUT: assert property (seqCmdWrite |=>
        frameRefPulseOut == $past(dataLast_r[CMD_FRAME_BIT], 1))
        else $error("frame output not taken from command bit");
    AST_SW_RESET: assert property (swReset_r |=> !txEmpty_r && !rxReady_r)
        else $error("software reset did not clear flags");
    AST_DEBUG_WR: assert property (wrDataEnd && destSel_r == DEST_DEBUG1
        |=> debugLatch1 == $past(dataLast_r, 1))
        else $error("debug write did not reach its latch");
    AST_TX_EMPTY: assert property (seqWordLive |=> txEmpty_r)
        else $error("transmit empty not set on word edge");
    AST_TX_UNDER: assert property (seqWordLive ##0 txEmpty_r |=> txUnder_r)
        else $error("underflow not captured");
    AST_RX_LATCH: assert property (seqWordLive |=>
        rxLatch_r == $past(rxShiftNxt, 1))
        else $error("receive word not latched");
    AST_RX_OVR: assert property (seqWordLive ##0 rxReady_r |=> status_rx_overflow_r)
        else $error("overflow not set on unread word");
    AST_RX_HOLD: assert property (rxReady_r && !rdDataEnd && !boardRst
        |=> rxReady_r)
        else $error("receive ready dropped without clear");
    AST_READ_DATA: assert property (!readDataSelectN |=>
        hostDataOe && hostDataOut == {4'h0, $past(rxLatch_r, 1)})
        else $error("read data not driven from receive latch");
endmodule
`default_nettype wire

// File: rtl/hsdi_pkg.sv
package hsdi_pkg;
    // ==========================================
    // Widths
    localparam int HOST_W   = 16;
    localparam int WORD_W   = 12;
    localparam int FIFO_DEPTH = 8;

    // ==========================================
    // Command register fields
    localparam int CMD_DEST_LSB  = 0;
    localparam int CMD_FRAME_BIT = 2;
    localparam int CMD_SWRST_BIT = 15;
    localparam logic [1:0] DEST_TX_HOLD = 2'h0;
    localparam logic [1:0] DEST_DEBUG1  = 2'h1;
    localparam logic [1:0] DEST_DEBUG2  = 2'h2;
    localparam logic [1:0] DEST_DEBUG3  = 2'h3;

    // ==========================================
    // Status register fields
    localparam int STAT_RX_READY = 15;
    localparam int STAT_RX_OVR   = 14;
    localparam int STAT_TX_EMPTY = 13;
    localparam int STAT_TX_UNDER = 12;
    localparam int STAT_FRAME    = 11;

    // ==========================================
    // Clock division counts
    localparam int DIV_432      = 180;
    localparam logic [7:0] DIV_432_LAST = 8'(DIV_432 - 1);
    localparam int BITS_PER_WORD = 12;
    localparam logic [3:0] WORD_LAST = 4'(BITS_PER_WORD - 1);

    // ==========================================
    // Reset values
    localparam logic [HOST_W-1:0] HOST_ZERO = 16'h0000;
    localparam logic [WORD_W-1:0] WORD_ZERO = 12'h000;
endpackage

// File: rtl/hsdi_fifo_if.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Transmit word path between block and FIFO
interface hsdi_fifo_if;
    logic                      inValid;
    logic                      inReady;
    logic [hsdi_pkg::HOST_W-1:0] inData;
    logic                      outValid;
    logic                      outReady;
    logic [hsdi_pkg::HOST_W-1:0] outData;
    modport source (output inValid, input inReady, output inData,
                    input outValid, output outReady, input outData);
    modport fifo   (input inValid, output inReady, input inData,
                    output outValid, input outReady, output outData);
endinterface
`default_nettype wire

// File: rtl/hsdi_fifo.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Synchronous FIFO in flip-flops
module hsdi_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    input  wire logic clk_sys,
    input  wire logic reset_n,
    input  wire logic flush,
    hsdi_fifo_if.fifo port
);
    import hsdi_pkg::*;
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
    localparam logic [AW-1:0] LAST_IDX = AW'(DEPTH - 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wrIdx_r;
    logic [AW-1:0]    rdIdx_r;
    logic [CW-1:0]    count_r;
    logic             doPush;
    logic             doPop;

    // Handshake terms
    assign port.inReady  = (count_r != FULL_CNT);
    assign port.outValid = (count_r != '0);
    assign port.outData  = mem[rdIdx_r];
    assign doPush = port.inValid && port.inReady;
    assign doPop  = port.outValid && port.outReady;

    // Storage write
    always_ff @(posedge clk_sys) begin
        if (doPush) begin
            mem[wrIdx_r] <= port.inData;
        end
    end

    // Pointers and fill count
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            wrIdx_r <= '0;
            rdIdx_r <= '0;
            count_r <= '0;
        end else if (flush) begin
            wrIdx_r <= '0;
            rdIdx_r <= '0;
            count_r <= '0;
        end else begin
            if (doPush) begin
                wrIdx_r <= (wrIdx_r == LAST_IDX) ? '0 : wrIdx_r + 1'b1;
            end
            if (doPop) begin
                rdIdx_r <= (rdIdx_r == LAST_IDX) ? '0 : rdIdx_r + 1'b1;
            end
            if (doPush && !doPop) begin
                count_r <= count_r + 1'b1;
            end else if (doPop && !doPush) begin
                count_r <= count_r - 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// File: bench/hsdi_serial_partner.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Serial device: bit clock, receive source, transmit sink
module hsdi_serial_partner #(
    parameter logic [11:0] PAT = 12'ha5c
) (
    input  wire logic        clk_sys,
    input  wire logic        reset_n,
    input  wire logic        serialDataOut,
    output logic             extClk2400,
    output logic             serialDataIn,
    output logic [15:0]      bitCount,
    output logic [11:0]      wordOut,
    output logic             wordDone
);
    // Free-running bit clock, counted from reset release
    initial begin
        extClk2400 = 1'b0;
        serialDataIn = PAT[0];
        bitCount = 16'h0000;
        wordOut = 12'h000;
        wordDone = 1'b0;
        wait (reset_n === 1'b1);
        forever begin
            repeat (8) @(posedge clk_sys);
            #2 extClk2400 = 1'b1;
            bitCount = bitCount + 16'h0001;
            repeat (8) @(posedge clk_sys);
            #2 extClk2400 = 1'b0;
            // Collect sent bit, present the next receive bit
            wordOut[bitCount % 12] = serialDataOut;
            serialDataIn = PAT[bitCount % 12];
            wordDone = (bitCount % 12 == 11) && (bitCount > 22);
            @(posedge clk_sys);
            #2 wordDone = 1'b0;
        end
    end
endmodule
`default_nettype wire

// File: bench/hsdi_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin totalChecks++; if ((g) !== (e)) begin badCount++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
// ==========================================
// Self-checking bench with a flag and word queue model
module hsdi_top_tb;
    import hsdi_pkg::*;
    localparam logic [11:0] PAT = 12'ha5c;
    logic        clk_sys, reset_n, strobeN, wnr, frameIn, frameOut, holdRdy;
    logic        bufEnN, oe, sOut, sIn, ext2400, wDone, clkSel, ext432;
    logic [3:0]  addr;
    logic [2:0]  base;
    logic [15:0] dIn, dOut, dbg1, dbg2, dbg3, bitCount, rd, v;
    logic [11:0] wOut, curTx;
    logic [11:0] txQ[$];
    int          badCount, totalChecks, seed, cyc;
    bit          status_rx_ready, status_rx_overflow, txE, txU, linkOff;

    hsdi_top uut (.clk_sys(clk_sys), .reset_n(reset_n),
        .ioAccessStrobeN(strobeN), .hostWriteNotRead(wnr),
        .hostAddr(addr), .hostDataIn(dIn), .hostDataOut(dOut),
        .hostDataOe(oe), .busBufferEnableN(bufEnN),
        .baseAddrSwitch(base), .clockSourceSelect(clkSel),
        .extClk2400(ext2400), .extClk432(ext432), .serialDataIn(sIn),
        .serialDataOut(sOut), .frameRefPulse(frameIn),
        .frameRefPulseOut(frameOut), .txHoldReady(holdRdy),
        .debugLatch1(dbg1), .debugLatch2(dbg2), .debugLatch3(dbg3));
    hsdi_serial_partner #(.PAT(PAT)) partner (.clk_sys(clk_sys),
        .reset_n(reset_n), .serialDataOut(sOut), .extClk2400(ext2400),
        .serialDataIn(sIn), .bitCount(bitCount), .wordOut(wOut),
        .wordDone(wDone));

    // Clock and hang guard
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            badCount++;
            stopTest();
        end
    end

    // Word tick of the model
    always @(bitCount) begin
        if (bitCount != 0 && bitCount % 12 == 0 && !linkOff) begin
            txU = txU | txE;
            txE = 1;
            status_rx_overflow = status_rx_overflow | status_rx_ready;
            status_rx_ready = 1;
            if (txQ.size() > 0) curTx = txQ.pop_front();
        end
    end
    always @(posedge wDone) if (!linkOff) `CHK(wOut, curTx)

    task automatic stopTest();
        $display("checks %0d mismatches %0d", totalChecks, badCount);
        if (badCount == 0 && totalChecks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // One access: strobe low six cycles, high four
    task automatic acc(input bit we, input bit a0, input logic [15:0] d,
                       input bit hit);
        addr = {hit ? base : ~base, a0};
        wnr = ~we;
        dIn = d;
        strobeN = 1'b0;
        repeat (6) @(posedge clk_sys);
        #2 `CHK(bufEnN, ~hit)
        `CHK(oe, hit & ~we)
        rd = dOut;
        strobeN = 1'b1;
        dIn = ~d;
        repeat (4) @(posedge clk_sys);
        #2;
    endtask
    task automatic stat();
        frameIn = 1'($random(seed));
        acc(0, 1, 16'h0000, 1);
        `CHK(rd, {status_rx_ready, status_rx_overflow, txE, txU, frameIn, 11'h000})
        status_rx_overflow = 0;
    endtask
    task automatic wr(input logic [15:0] d);
        acc(1, 0, d, 1);
        txQ.push_back(d[11:0]);
        txE = 0;
        txU = 0;
    endtask
    task automatic waitBit(input int n);
        wait (bitCount == n);
        @(posedge clk_sys);
        #2;
    endtask
    // Rising edges on the fast external clock, two cycles high, two low
    task automatic pulse432(input int n);
        repeat (n) begin
            ext432 = 1'b1;
            repeat (2) @(posedge clk_sys);
            #2 ext432 = 1'b0;
            repeat (2) @(posedge clk_sys);
            #2;
        end
    endtask

    initial begin
        seed = 31;
        curTx = 12'h000;
        {strobeN, wnr, addr, dIn, frameIn} = {2'h3, 4'h0, 16'h0000, 1'b0};
        {clkSel, ext432, linkOff} = 3'h4;
        base = 3'($random(seed));
        reset_n = 1'b0;
        repeat (16) @(posedge clk_sys);
        #2 reset_n = 1'b1;
        repeat (4) @(posedge clk_sys);
        #2 stat();
        acc(1, 1, 16'h0004, 1);
        `CHK(frameOut, 1'b1)
        for (int i = 1; i < 4; i++) begin
            v = 16'($random(seed));
            acc(1, 1, {13'h0000, i[2:0]}, 1);
            acc(1, 0, v, 1);
            `CHK(i == 1 ? dbg1 : i == 2 ? dbg2 : dbg3, v)
        end
        acc(1, 1, 16'h0000, 1);
        acc(1, 1, 16'h0007, 0);
        `CHK(frameOut, 1'b0)
        $display("test command done");
        waitBit(13);
        stat();
        acc(0, 0, 16'h0000, 1);
        `CHK(rd, {4'h0, PAT})
        status_rx_ready = 0;
        wr(16'($random(seed)));
        stat();
        waitBit(25);
        stat();
        waitBit(37);
        stat();
        `CHK(holdRdy, 1'b1)
        repeat (8) wr(16'($random(seed)));
        `CHK(holdRdy, 1'b0)
        acc(1, 0, 16'h0fff, 1);
        $display("test stream done");
        waitBit(145);
        {clkSel, linkOff} = 2'h1;
        acc(1, 1, 16'h8000, 1);
        acc(1, 1, 16'h0000, 1);
        {status_rx_ready, status_rx_overflow, txE, txU} = 4'h0;
        stat();
        $display("test soft reset done");
        pulse432(2159);
        stat();
        pulse432(1);
        {status_rx_ready, txE} = 2'h3;
        stat();
        $display("test slow clock done");
        stopTest();
    end
endmodule
`default_nettype wire
